// *** hw/otgsi_defs.vh ***
// Register map, field positions and reset values for the OTG status and interrupt block
`ifndef OTGSI_DEFS_VH
`define OTGSI_DEFS_VH

`define OTGSI_AW 4
`define OTGSI_OFS_OTG_CS 4'h0
`define OTGSI_OFS_OTG_IRQ 4'h4
`define OTGSI_OFS_BUS_CS 4'h8
`define OTGSI_OFS_GIRQ_FLAG 4'hc
`define OTGSI_CS_RESET 32'h00000800
`define OTGSI_ZERO32 32'h00000000

// Control and status fields
`define OTGSI_B_SES 19
`define OTGSI_A_SES 18
`define OTGSI_DEB 17
`define OTGSI_IDL 16
`define OTGSI_B_NEG_EN 11
`define OTGSI_A_NEG_EN 10
`define OTGSI_NEG_REQ 9
`define OTGSI_NEG_OK 8
`define OTGSI_SES_REQ 1
`define OTGSI_SES_OK 0

// OTG interrupt flag fields and the bus control global enable
`define OTGSI_NEG_END 9
`define OTGSI_SES_END 8
`define OTGSI_GIRQ_EN 0
// Per-source enables start at this bit of the bus control word
`define OTGSI_FLAG_EN_LSB 6
// Reset level of the B side negotiation enable (control word resets to 0x800)
`define OTGSI_B_NEG_EN_RST 1'b1
// Padding that fills bits 5:1 of the bus control image and the upper bits of the flag image
`define OTGSI_BUS_PAD 5'h00
`define OTGSI_FLAG_PAD 6'h00

// Global source flag vector: 25 sources plus wakeup
`define OTGSI_NSRC 26
`define OTGSI_SRC_W 26
`define OTGSI_WAKE_BIT 25
// Mask of sources kept in host mode, device mode
`define OTGSI_HOST_MASK 26'h3fc007f
`define OTGSI_DEV_MASK 26'h3fbffc5

`endif

// *** hw/otgsi_core.v ***
// OTG session, negotiation status and global interrupt source grouping
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "otgsi_defs.vh"

module otgsi_core (
    input wire core_clk,
    input wire resetn,
    input wire [`OTGSI_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire host_mode,
    input wire b_session_valid,
    input wire a_session_valid,
    input wire debounce_kind,
    input wire id_level,
    input wire neg_done,
    input wire neg_ok,
    input wire peer_neg_req,
    input wire ses_done,
    input wire ses_ok,
    input wire [`OTGSI_SRC_W-2:0] src_event,
    input wire wake_event,
    output reg neg_start,
    output reg peer_neg_accept,
    output reg ses_start,
    output wire global_irq,
    output wire wakeup_irq
);

    // Control register state
    reg b_neg_en_q;
    reg a_neg_en_q;
    reg neg_req_q;
    reg neg_ok_q;
    reg ses_req_q;
    reg ses_ok_q;
    reg neg_end_q;
    reg ses_end_q;
    reg girq_en_q;
    reg [`OTGSI_SRC_W-1:0] flag_q;
    reg [`OTGSI_SRC_W-1:0] flag_en_q;
    reg [`OTGSI_SRC_W-1:0] mode_mask;
    reg [31:0] cs_val;
    reg [31:0] irq_val;

    // Register map as seen from the plain register port
    //
    // Offset 0x0, OTG control and status word
    //   bit 19  B session valid, live level from the transceiver, read only
    //   bit 18  A session valid, live level from the transceiver, read only
    //   bit 17  Debounce kind of the last connection, live level, read only
    //   bit 16  ID pin level, live level, read only
    //   bit 11  B side negotiation enable, read-write, comes out of reset set
    //   bit 10  A side negotiation enable, read-write, comes out of reset clear
    //   bit 9   Negotiation request, set by software, dropped only after the end flag
    //   bit 8   Negotiation success, set by the link, cleared by a new request
    //   bit 1   Session request, set by software, dropped only after the end flag
    //   bit 0   Session request success, set by the link, cleared by a new request
    //   Every other bit reads zero and ignores writes.
    //
    // Offset 0x4, OTG event flags, write one to clear
    //   bit 9   Negotiation finished
    //   bit 8   Session request finished
    //
    // Offset 0x8, bus control word
    //   bit 0       Global interrupt enable
    //   bits 31:6   One enable per global source, source i at bit i+6
    //
    // Offset 0xc, global source flags, write one to clear
    //   bits 25:0   One sticky flag per source, wakeup in the top bit
    //
    // Source bit order of the global flag word and of src_event
    //   0   Session event, both modes
    //   1   Disconnect, host only
    //   2   ID level change, both modes
    //   3   Periodic transmit queue empty, host only
    //   4   Host channels summary, host only
    //   5   Host port summary, host only
    //   6   Shared incomplete bit: periodic in host, iso OUT in device
    //   7   Iso IN incomplete, device only
    //   8   OUT endpoint summary, device only
    //   9   IN endpoint summary, device only
    //   10  End of periodic frame, device only
    //   11  Iso OUT packet dropped, device only
    //   12  Enumeration done, device only
    //   13  Bus reset seen, device only
    //   14  Suspend, device only
    //   15  Early suspend, device only
    //   16  Global OUT NAK in force, device only
    //   17  Global IN NAK in force, device only
    //   18  Nonperiodic transmit queue empty, host only
    //   19  Receive queue not empty, both modes
    //   20  Frame start, both modes
    //   21  OTG summary, both modes
    //   22  Mode fault, both modes
    //   23  Spare, both modes
    //   24  Spare, both modes
    //   25  Wakeup, fed by its own input and never masked by mode
    //
    // Behaviour worth knowing
    //   A source event is qualified by the mode level in the same cycle it
    //   arrives, so a mode change only affects events that come after it.
    //   Flags are sticky: an event in the same cycle as a clear write wins,
    //   so software never loses an event that lands on top of its clear.
    //   The same holds for the two OTG end flags.
    //   A request bit cannot be dropped before its end flag is up; a zero
    //   write before that leaves it set, which keeps software from cutting
    //   a handshake that the link side is still running.
    //   The negotiation start pulse looks at the enable value being written
    //   in the same word, so clearing the enable and requesting together
    //   never starts anything.
    //   The wakeup line is a plain level of its flag and needs no clock to
    //   hold; the global enable does not gate it.
    //   The global line is combinational from flops only, so it carries no
    //   glitch from the register port.
    //   Read data stand for exactly one cycle after the read strobe and are
    //   zero at all other times, which lets a shared read bus OR the slaves.
    //   Unmapped offsets read zero and ignore writes.

    // Address match helper used by the write decode only
    function hit;
        input [`OTGSI_AW-1:0] a;
        input [`OTGSI_AW-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_cs = reg_wr && hit(reg_addr, `OTGSI_OFS_OTG_CS);
    wire wr_irq = reg_wr && hit(reg_addr, `OTGSI_OFS_OTG_IRQ);
    wire wr_bus = reg_wr && hit(reg_addr, `OTGSI_OFS_BUS_CS);
    wire wr_gflag = reg_wr && hit(reg_addr, `OTGSI_OFS_GIRQ_FLAG);
    // Enable vector for the global sources sits in bits 31:6 of bus control
    wire neg_set = wr_cs && reg_wdata[`OTGSI_NEG_REQ] && !neg_req_q;
    wire ses_set = wr_cs && reg_wdata[`OTGSI_SES_REQ] && !ses_req_q;
    wire neg_end_clr = wr_irq && reg_wdata[`OTGSI_NEG_END];
    wire ses_end_clr = wr_irq && reg_wdata[`OTGSI_SES_END];

    // Mode qualification of source events
    always @* begin
        mode_mask = host_mode ? `OTGSI_HOST_MASK : `OTGSI_DEV_MASK;
    end

    // B side negotiation enable, set out of reset
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            b_neg_en_q <= `OTGSI_B_NEG_EN_RST;
        end else if (wr_cs) begin
            b_neg_en_q <= reg_wdata[`OTGSI_B_NEG_EN];
        end
    end

    // A side negotiation enable
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            a_neg_en_q <= 1'b0;
        end else if (wr_cs) begin
            a_neg_en_q <= reg_wdata[`OTGSI_A_NEG_EN];
        end
    end

    // Global interrupt enable
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            girq_en_q <= 1'b0;
        end else if (wr_bus) begin
            girq_en_q <= reg_wdata[`OTGSI_GIRQ_EN];
        end
    end

    // Negotiation request: set by software, dropped after end on zero write or end clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            neg_req_q <= 1'b0;
        end else if (neg_set) begin
            neg_req_q <= 1'b1;
        end else if (neg_end_q && ((wr_cs && !reg_wdata[`OTGSI_NEG_REQ]) || neg_end_clr)) begin
            neg_req_q <= 1'b0;
        end
    end

    // Session request: same life cycle as the negotiation request
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ses_req_q <= 1'b0;
        end else if (ses_set) begin
            ses_req_q <= 1'b1;
        end else if (ses_end_q && ((wr_cs && !reg_wdata[`OTGSI_SES_REQ]) || ses_end_clr)) begin
            ses_req_q <= 1'b0;
        end
    end

    // Start pulses to the link side; the B enable in the same word decides the negotiation start only
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            neg_start <= 1'b0;
            ses_start <= 1'b0;
            peer_neg_accept <= 1'b0;
        end else begin
            neg_start <= neg_set && reg_wdata[`OTGSI_B_NEG_EN];
            ses_start <= ses_set;
            peer_neg_accept <= peer_neg_req && a_neg_en_q;
        end
    end

    // Negotiation success flag
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            neg_ok_q <= 1'b0;
        end else if (neg_set) begin
            neg_ok_q <= 1'b0;
        end else if (neg_done && neg_ok) begin
            neg_ok_q <= 1'b1;
        end
    end

    // Session request success flag
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ses_ok_q <= 1'b0;
        end else if (ses_set) begin
            ses_ok_q <= 1'b0;
        end else if (ses_done && ses_ok) begin
            ses_ok_q <= 1'b1;
        end
    end

    // Negotiation end flag: set wins over clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            neg_end_q <= 1'b0;
        end else if (neg_done) begin
            neg_end_q <= 1'b1;
        end else if (neg_end_clr) begin
            neg_end_q <= 1'b0;
        end
    end

    // Session request end flag: set wins over clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ses_end_q <= 1'b0;
        end else if (ses_done) begin
            ses_end_q <= 1'b1;
        end else if (ses_end_clr) begin
            ses_end_q <= 1'b0;
        end
    end

    // Global source flags and their enables, one per bit
    genvar gi;
    generate
        for (gi = 0; gi < `OTGSI_NSRC; gi = gi + 1) begin : g_src
            wire ev;
            if (gi == `OTGSI_WAKE_BIT) begin : g_wk
                assign ev = wake_event;
            end else begin : g_ev
                assign ev = src_event[gi] && mode_mask[gi];
            end
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    flag_q[gi] <= 1'b0;
                    flag_en_q[gi] <= 1'b0;
                end else begin
                    if (ev) begin
                        flag_q[gi] <= 1'b1;
                    end else if (wr_gflag && reg_wdata[gi]) begin
                        flag_q[gi] <= 1'b0;
                    end
                    if (wr_bus) begin
                        flag_en_q[gi] <= reg_wdata[gi + `OTGSI_FLAG_EN_LSB];
                    end
                end
            end
        end
    endgenerate

    // Interrupt outputs
    assign global_irq = girq_en_q && |(flag_q[`OTGSI_WAKE_BIT-1:0] &
        flag_en_q[`OTGSI_WAKE_BIT-1:0]);
    // Wakeup line is a pure level of the flag so it holds without clock
    assign wakeup_irq = flag_q[`OTGSI_WAKE_BIT];

    // Register images
    always @* begin
        cs_val = `OTGSI_ZERO32;
        cs_val[`OTGSI_B_SES] = b_session_valid;
        cs_val[`OTGSI_A_SES] = a_session_valid;
        cs_val[`OTGSI_DEB] = debounce_kind;
        cs_val[`OTGSI_IDL] = id_level;
        cs_val[`OTGSI_B_NEG_EN] = b_neg_en_q;
        cs_val[`OTGSI_A_NEG_EN] = a_neg_en_q;
        cs_val[`OTGSI_NEG_REQ] = neg_req_q;
        cs_val[`OTGSI_NEG_OK] = neg_ok_q;
        cs_val[`OTGSI_SES_REQ] = ses_req_q;
        cs_val[`OTGSI_SES_OK] = ses_ok_q;
        irq_val = `OTGSI_ZERO32;
        irq_val[`OTGSI_NEG_END] = neg_end_q;
        irq_val[`OTGSI_SES_END] = ses_end_q;
    end

    // Read data, one cycle after the strobe
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `OTGSI_ZERO32;
        end else if (reg_rd) begin
            case (reg_addr)
                `OTGSI_OFS_OTG_CS: reg_rdata <= cs_val;
                `OTGSI_OFS_OTG_IRQ: reg_rdata <= irq_val;
                `OTGSI_OFS_BUS_CS: reg_rdata <= {flag_en_q, `OTGSI_BUS_PAD, girq_en_q};
                `OTGSI_OFS_GIRQ_FLAG: reg_rdata <= {`OTGSI_FLAG_PAD, flag_q};
                default: reg_rdata <= `OTGSI_ZERO32;
            endcase
        end else begin
            reg_rdata <= `OTGSI_ZERO32;
        end
    end

endmodule // otgsi_core

// *** tb/otgsi_peer.sv ***
// Cable partner model answering negotiation and session requests
`timescale 1ns/1ps
module otgsi_peer (
    input wire core_clk,
    input wire resetn,
    input wire neg_start,
    input wire ses_start,
    output reg neg_done,
    output reg neg_ok,
    output reg ses_done,
    output reg ses_ok
);
    reg [2:0] n_q;
    reg [2:0] s_q;
    // Answer each started request a few cycles later, with success
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            n_q <= 3'h0;
            s_q <= 3'h0;
            neg_done <= 1'h0;
            neg_ok <= 1'h0;
            ses_done <= 1'h0;
            ses_ok <= 1'h0;
        end else begin
            n_q <= {n_q[1:0], neg_start};
            s_q <= {s_q[1:0], ses_start};
            neg_done <= n_q[1] & ~n_q[2];
            neg_ok <= n_q[1] & ~n_q[2];
            ses_done <= s_q[1] & ~s_q[2];
            ses_ok <= s_q[1] & ~s_q[2];
        end
    end
endmodule // otgsi_peer

// *** tb/otgsi_core_properties.sv ***
// Port checker for the OTG status and interrupt block
`timescale 1ns/1ps
`include "otgsi_defs.vh"
module otgsi_core_properties (
    input wire core_clk,
    input wire resetn,
    input wire [`OTGSI_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire b_session_valid,
    input wire a_session_valid,
    input wire debounce_kind,
    input wire id_level,
    input wire [`OTGSI_SRC_W-2:0] src_event,
    input wire wake_event,
    input wire neg_start,
    input wire peer_neg_accept,
    input wire global_irq,
    input wire wakeup_irq
);
    reg [2:0] en_q;
    // Shadow of global enable, B and A negotiation enables
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 3'h2;
        end else if (reg_wr && reg_addr == `OTGSI_OFS_OTG_CS) begin
            en_q[1:0] <= reg_wdata[11:10];
        end else if (reg_wr && reg_addr == `OTGSI_OFS_BUS_CS) begin
            en_q[2] <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_live; reg_rd && reg_addr == 4'h0 |=> reg_rdata[19:16] ==
        $past({b_session_valid, a_session_valid, debounce_kind, id_level}); endproperty
    a_live: assert property (p_live) else $error("pin bits misread");
    property p_rd0; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside slot");
    property p_wset; wake_event |=> wakeup_irq; endproperty
    a_wset: assert property (p_wset) else $error("wakeup not raised");
    property p_wrose; $rose(wakeup_irq) |-> $past(wake_event); endproperty
    a_wrose: assert property (p_wrose) else $error("wakeup without cause");
    property p_wfell; $fell(wakeup_irq) |-> $past(reg_wr && reg_wdata[25]); endproperty
    a_wfell: assert property (p_wfell) else $error("wakeup lost");
    property p_grose; $rose(global_irq) |-> $past(|src_event || wake_event || reg_wr);
    endproperty
    a_grose: assert property (p_grose) else $error("global irq without cause");
    property p_gate; global_irq |-> en_q[2]; endproperty
    a_gate: assert property (p_gate) else $error("global irq while disabled");
    property p_bneg; neg_start |-> en_q[1]; endproperty
    a_bneg: assert property (p_bneg) else $error("negotiation while disabled");
    property p_aneg; peer_neg_accept |-> en_q[0]; endproperty
    a_aneg: assert property (p_aneg) else $error("peer request honoured");
endmodule // otgsi_core_properties

// *** tb/otgsi_core_tb_top.sv ***
// Self-checking bench for the OTG status and interrupt block
`timescale 1ns/1ps
`include "otgsi_defs.vh"
module otgsi_core_tb_top;
    reg core_clk = 1'h0;
    reg resetn = 1'h0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'h0;
    reg reg_rd = 1'h0;
    reg host_mode = 1'h0;
    reg [3:0] pins = 4'ha;
    reg peer_neg_req = 1'h0;
    reg [24:0] src_event = 25'h0;
    reg wake_event = 1'h0;
    reg [24:0] m;
    reg [24:0] b;
    wire [31:0] reg_rdata;
    wire neg_done, neg_ok, ses_done, ses_ok, neg_start, ses_start, peer_neg_accept;
    wire global_irq, wakeup_irq;
    integer fail_count = 0;
    integer n_tests = 0;
    integer i;
    integer k;
    always #10 core_clk = ~core_clk;
    otgsi_core u_otgsi_core (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .host_mode, .b_session_valid(pins[3]), .a_session_valid(pins[2]),
        .debounce_kind(pins[1]), .id_level(pins[0]), .neg_done, .neg_ok, .peer_neg_req,
        .ses_done, .ses_ok, .src_event, .wake_event, .neg_start, .peer_neg_accept,
        .ses_start, .global_irq, .wakeup_irq);
    otgsi_peer u_otgsi_peer (.core_clk, .resetn, .neg_start, .ses_start, .neg_done,
        .neg_ok, .ses_done, .ses_ok);
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Full-word register write and read
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_wr <= 1'h1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'h0;
        end
    endtask
    task rd(input string nm, input [3:0] a, input [31:0] e);
        begin
            @(posedge core_clk);
            reg_rd <= 1'h1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'h0;
            #1 chk(nm, reg_rdata, e);
        end
    endtask
    // One-cycle pulse on the wakeup and source event inputs
    task ev(input [25:0] v);
        begin
            @(posedge core_clk);
            {wake_event, src_event} <= v;
            @(posedge core_clk);
            {wake_event, src_event} <= 26'h0;
        end
    endtask
    task peer(input e);
        begin
            @(posedge core_clk);
            peer_neg_req <= 1'h1;
            @(posedge core_clk);
            peer_neg_req <= 1'h0;
            #1 chk("accept", peer_neg_accept, e);
        end
    endtask
    // Bounded wait for the partner to end a request
    task wt;
        begin
            k = 0;
            while (!(neg_done | ses_done) && k < 20) begin
                @(posedge core_clk);
                k = k + 1;
            end
            if (k == 20) begin
                fail_count = fail_count + 1;
                conclude;
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'h1;
        rd("cs reset", `OTGSI_OFS_OTG_CS, `OTGSI_CS_RESET | 32'ha0000);
        pins <= 4'h5;
        rd("cs pins", `OTGSI_OFS_OTG_CS, 32'h50800);
        rd("unmapped", 4'h2, 32'h0);
        wr(`OTGSI_OFS_OTG_CS, 32'h800);
        wr(`OTGSI_OFS_OTG_CS, 32'ha00);
        wt;
        rd("neg end", `OTGSI_OFS_OTG_IRQ, 32'h200);
        rd("neg ok", `OTGSI_OFS_OTG_CS, 32'h50b00);
        wr(`OTGSI_OFS_OTG_IRQ, 32'h200);
        rd("neg clear", `OTGSI_OFS_OTG_CS, 32'h50900);
        wr(`OTGSI_OFS_OTG_CS, 32'h200);
        rd("neg req", `OTGSI_OFS_OTG_CS, 32'h50200);
        rd("neg none", `OTGSI_OFS_OTG_IRQ, 32'h0);
        wr(`OTGSI_OFS_OTG_CS, 32'h602);
        wt;
        rd("ses ok", `OTGSI_OFS_OTG_CS, 32'h50603);
        rd("ses end", `OTGSI_OFS_OTG_IRQ, 32'h100);
        wr(`OTGSI_OFS_OTG_CS, 32'h600);
        rd("ses clear", `OTGSI_OFS_OTG_CS, 32'h50601);
        wr(`OTGSI_OFS_OTG_IRQ, 32'h100);
        peer(1'h1);
        wr(`OTGSI_OFS_OTG_CS, 32'h200);
        peer(1'h0);
        wr(`OTGSI_OFS_BUS_CS, 32'hffffffc1);
        for (i = 0; i < 50; i = i + 1) begin
            host_mode <= i[0];
            m = i[0] ? ~25'h3ff80 : ~25'h4003a;
            b = 25'h1 << (i / 2);
            wr(`OTGSI_OFS_GIRQ_FLAG, 32'h3ffffff);
            ev({1'h0, b});
            rd("flag", `OTGSI_OFS_GIRQ_FLAG, {7'h0, m & b});
            chk("global", global_irq, |(m & b));
        end
        wr(`OTGSI_OFS_BUS_CS, 32'hffffffc0);
        #1 chk("global off", global_irq, 1'h0);
        ev(26'h2000000);
        #1 chk("wake set", wakeup_irq, 1'h1);
        rd("wake flag", `OTGSI_OFS_GIRQ_FLAG, 32'h3000000);
        wr(`OTGSI_OFS_GIRQ_FLAG, 32'h2000000);
        #1 chk("wake clear", wakeup_irq, 1'h0);
        conclude;
    end
endmodule // otgsi_core_tb_top
bind otgsi_core otgsi_core_properties u_chk (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .b_session_valid, .a_session_valid, .debounce_kind,
    .id_level, .src_event, .wake_event, .neg_start, .peer_neg_accept, .global_irq,
    .wakeup_irq);
